// [rtl/eisc_det_if.sv]
// Connection between the top block and one request detector
`timescale 1ns/1ps
interface eisc_det_if;
    logic       sense;
    logic [1:0] dir;
    logic       level;
    logic       lvl_req;
    logic       edge_evt;
    modport det (input sense, input dir, output level, output lvl_req, output edge_evt);
    modport ctl (output sense, output dir, input level, input lvl_req, input edge_evt);
endinterface

// [rtl/eisc_ext_detect.sv]
// Synchroniser with level and edge detection for one maskable request pin
`timescale 1ns/1ps
module eisc_ext_detect (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic reset_n_in,
    // Pin, active low
    input  wire logic pin_in,
    // Configuration and results
    eisc_det_if.det   det
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic edge_evt;
    } eisc_det_s;

    eisc_det_s st_reg;
    eisc_det_s st_next;
    logic      rise;
    logic      fall;

    always_comb begin
        st_next      = st_reg;
        st_next.s1   = pin_in;
        st_next.s2   = st_reg.s1;
        st_next.prev = st_reg.s2;
        rise         = st_reg.s2 & ~st_reg.prev;
        fall         = ~st_reg.s2 & st_reg.prev;
        // Code 11 is illegal and detects nothing
        case (det.dir)
            eisc_pkg::DIR_FALL: st_next.edge_evt = det.sense & fall;
            eisc_pkg::DIR_RISE: st_next.edge_evt = det.sense & rise;
            eisc_pkg::DIR_BOTH: st_next.edge_evt = det.sense & (rise | fall);
            default:            st_next.edge_evt = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            // Pins idle high; a zero here would look like a request after reset
            st_reg <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, edge_evt: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign det.level    = st_reg.s2;
    assign det.lvl_req  = ~det.sense & ~st_reg.s2;
    assign det.edge_evt = st_reg.edge_evt;

    chk_sync_depth: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        $past(reset_n_in, 2) |-> det.level == $past(pin_in, 2))
        else $error("Pin level not delayed by two flops");

    chk_both_edges: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        det.sense && det.dir == eisc_pkg::DIR_BOTH && $changed(st_reg.s2) |=> det.edge_evt)
        else $error("Edge missed in both-edge mode");

    chk_bad_code: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        det.dir == 2'b11 |=> !det.edge_evt)
        else $error("Illegal direction code raised an edge");
endmodule

// [rtl/eisc_ext_irq_sense_config.sv]
// External request sensing, control register and prioritised forwarding
// ------------------------------------------------------------
// Notes on behaviour
// - Sixteen priority levels arbitrate pending sources; only the winner reaches the CPU.
// - Non-maskable input is noise filtered before an edge counts.
// - A dedicated pin tells outside logic that a request is active.
// - One non-maskable and eight maskable inputs, each maskable or prioritised.
// - Sense control register is sixteen bits, software readable and writable.
// - Bit 15 reads the non-maskable pin level; writes ignore it.
// - Bits 14 to 9 read zero; software writes zero.
// - Bit 8 picks non-maskable edge, 0 falling, 1 rising, reset 0.
// - Bits 7..0 pick mode of inputs 0..7 in reverse order, reset 0.
// - Sense 0 means low level requests; sense 1 means edge per direction field.
// - Direction 00 falling, 01 rising, 10 both, 11 illegal, ignored in level mode.
// ------------------------------------------------------------
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module eisc_ext_irq_sense_config (
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    // Request pins
    input  wire logic        nonmask_req_in,
    input  wire logic [7:0]  ext_request_n_in,
    // From the rest of the controller
    input  wire logic [15:0] edge_direction_control_in,
    input  wire logic [31:0] src_priority_in,
    // Register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [15:0] reg_rdata_out,
    // CPU request side
    input  wire logic        cpu_ack_in,
    input  wire logic [3:0]  cpu_ack_src_in,
    output logic             cpu_req_out,
    output logic      [3:0]  cpu_req_src_out,
    output logic      [4:0]  cpu_req_level_out,
    // Notification pin and event interrupt
    output logic             request_notify_n_out,
    output logic             irq_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [8:0]  ctl;
        logic [8:0]  pend;
        logic [7:0]  lvl_prev;
        logic        nmi_prev;
        logic [8:0]  stat;
        logic [8:0]  mask;
        logic [15:0] rdata;
        logic        req;
        logic [3:0]  src;
        logic [4:0]  lvl;
        logic        notify_n;
        logic        irq;
    } eisc_top_s;

    eisc_top_s  st_reg;
    eisc_top_s  st_next;

    logic       nmi_filt;
    logic [7:0] lvl_req;
    logic [7:0] edge_evt;
    logic [7:0] pin_lvl;

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    eisc_noise_filter u_nmi_filter (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .raw_in     (nonmask_req_in),
        .filt_out   (nmi_filt)
    );

    // One detector per maskable pin
    for (genvar i = 0; i < eisc_pkg::N_EXT; i++) begin : g_ext
        eisc_det_if det_if ();
        assign det_if.sense = st_reg.ctl[7-i];
        assign det_if.dir   = edge_direction_control_in[15-2*i -: 2];
        assign lvl_req[i]   = det_if.lvl_req;
        assign edge_evt[i]  = det_if.edge_evt;
        assign pin_lvl[i]   = det_if.level;
        eisc_ext_detect u_det (
            .mclk_in    (mclk_in),
            .reset_n_in (reset_n_in),
            .pin_in     (ext_request_n_in[i]),
            .det        (det_if.det)
        );
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic       nmi_edge;
    logic [8:0] events;
    logic [8:0] w1c;
    logic [8:0] active;
    logic [4:0] best_lvl;
    logic [3:0] best_src;
    logic [3:0] prio;

    always_comb begin
        st_next  = st_reg;
        nmi_edge = 1'b0;
        events   = '0;
        w1c      = '0;
        active   = '0;
        best_lvl = eisc_pkg::LVL_NONE;
        best_src = '0;
        prio     = '0;

        // Non-maskable edge on the filtered level
        if (st_reg.ctl[eisc_pkg::NONMASK_EDGE_SELECT_BIT]) begin
            nmi_edge = nmi_filt & ~st_reg.nmi_prev;
        end else begin
            nmi_edge = ~nmi_filt & st_reg.nmi_prev;
        end
        st_next.nmi_prev = nmi_filt;
        // Held low pin logs one status event, not one per cycle
        st_next.lvl_prev = lvl_req;

        // Level requests count as an event only when they start
        events = {nmi_edge, edge_evt | (lvl_req & ~st_reg.lvl_prev)};

        // Edge requests stay pending until the CPU takes them; set wins
        if (cpu_ack_in && cpu_ack_src_in <= eisc_pkg::SRC_NMI) begin
            st_next.pend[cpu_ack_src_in] = 1'b0;
        end
        st_next.pend = st_next.pend | {nmi_edge, edge_evt};

        // Arbitration: ties go to the lower input number
        for (int i = 0; i < eisc_pkg::N_EXT; i++) begin
            prio = src_priority_in[4*i +: 4];
            active[i] = (lvl_req[i] | st_reg.pend[i]) && prio != eisc_pkg::PRIO_OFF;
            if (active[i] && {1'b0, prio} > best_lvl) begin
                best_lvl = {1'b0, prio};
                best_src = 4'(i);
            end
        end
        // Non-maskable outranks every programmable level
        active[8] = st_reg.pend[8];
        if (st_reg.pend[8]) begin
            best_lvl = eisc_pkg::LVL_NMI;
            best_src = eisc_pkg::SRC_NMI;
        end
        st_next.req      = best_lvl != eisc_pkg::LVL_NONE;
        st_next.src      = best_src;
        st_next.lvl      = best_lvl;
        st_next.notify_n = best_lvl == eisc_pkg::LVL_NONE;

        // Register writes
        if (reg_wr_in) begin
            if (reg_addr_in == eisc_pkg::OFS_SENSE) begin
                st_next.ctl = reg_wdata_in[8:0];
            end else if (reg_addr_in == eisc_pkg::OFS_STATUS) begin
                w1c = reg_wdata_in[8:0];
            end else if (reg_addr_in == eisc_pkg::OFS_MASK) begin
                st_next.mask = reg_wdata_in[8:0];
            end
        end
        st_next.stat = (st_reg.stat & ~w1c) | events;
        st_next.irq  = |(st_next.stat & st_next.mask);

        // Read data stands for one cycle only
        st_next.rdata = '0;
        if (reg_rd_in) begin
            if (reg_addr_in == eisc_pkg::OFS_SENSE) begin
                st_next.rdata = {nmi_filt, eisc_pkg::RSVD_VAL, st_reg.ctl};
            end else if (reg_addr_in == eisc_pkg::OFS_STATUS) begin
                st_next.rdata = {7'h00, st_reg.stat};
            end else if (reg_addr_in == eisc_pkg::OFS_MASK) begin
                st_next.rdata = {7'h00, st_reg.mask};
            end else begin
                st_next.rdata = '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            st_reg          <= '0;
            st_reg.ctl      <= eisc_pkg::SENSE_RST;
            st_reg.stat     <= eisc_pkg::STATUS_RST;
            st_reg.mask     <= eisc_pkg::MASK_RST;
            st_reg.notify_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_out        = st_reg.rdata;
    assign cpu_req_out          = st_reg.req;
    assign cpu_req_src_out      = st_reg.src;
    assign cpu_req_level_out    = st_reg.lvl;
    assign request_notify_n_out = st_reg.notify_n;
    assign irq_out              = st_reg.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_nmi_fall_sel;
        !st_reg.ctl[8] && $fell(nmi_filt);
    endsequence

    sequence s_sense_read;
        reg_rd_in && reg_addr_in == eisc_pkg::OFS_SENSE;
    endsequence

    property p_nmi_forwarded;
        s_nmi_fall_sel |-> ##2 (cpu_req_out && cpu_req_src_out == eisc_pkg::SRC_NMI);
    endproperty

    chk_nmi_forward: assert property (p_nmi_forwarded)
        else $error("Falling non-maskable edge not forwarded");

    chk_winner_level: assert property (
        cpu_req_out && !cpu_req_level_out[4] |->
        cpu_req_level_out[3:0] == 4'($past(src_priority_in) >> (4 * cpu_req_src_out)))
        else $error("Presented level differs from source priority");

    chk_nonmask_pin_level_read: assert property (
        s_sense_read |=> reg_rdata_out[15] == $past(nmi_filt))
        else $error("Level bit does not show the pin");

    chk_rsvd_zero: assert property (
        s_sense_read |=> reg_rdata_out[14:9] == 6'h00)
        else $error("Reserved bits read non-zero");

    chk_edge_sel_wr: assert property (
        reg_wr_in && reg_addr_in == eisc_pkg::OFS_SENSE |=>
        st_reg.ctl == $past(reg_wdata_in[8:0]))
        else $error("Sense control write not taken");

    chk_sense_reset: assert property (
        @(posedge mclk_in) disable iff (1'b0)
        reset_n_in && !$past(reset_n_in) |-> st_reg.ctl == 9'h000)
        else $error("Sense control not zero after reset");

    chk_low_level_req: assert property (
        !st_reg.ctl[7] && !pin_lvl[0] && src_priority_in[3:0] != 4'h0 |=> cpu_req_out)
        else $error("Low level on input 0 not forwarded");

    chk_notify_pin: assert property (
        request_notify_n_out == !cpu_req_out)
        else $error("Notification pin disagrees with request");

    chk_irq_level: assert property (
        irq_out == |(st_reg.stat & st_reg.mask))
        else $error("Interrupt output disagrees with status and mask");

    // ------------------------------------------------------------
    // Register port checks
    // ------------------------------------------------------------
    // Stale read data would let a later poll see old bits
    chk_rdata_idle: assert property (
        !reg_rd_in |=> reg_rdata_out == 16'h0000)
        else $error("Read data stands without a read");

    chk_unmapped_read: assert property (
        reg_rd_in && reg_addr_in != eisc_pkg::OFS_SENSE &&
        reg_addr_in != eisc_pkg::OFS_STATUS &&
        reg_addr_in != eisc_pkg::OFS_MASK |=> reg_rdata_out == 16'h0000)
        else $error("Unmapped address returned data");

    chk_ctl_stable: assert property (
        !(reg_wr_in && reg_addr_in == eisc_pkg::OFS_SENSE) |=> $stable(st_reg.ctl))
        else $error("Sense control changed without a write");

    chk_mask_read: assert property (
        reg_rd_in && reg_addr_in == eisc_pkg::OFS_MASK |=>
        reg_rdata_out == {7'h00, $past(st_reg.mask)})
        else $error("Mask read differs from mask register");

    // ------------------------------------------------------------
    // Forwarding checks
    // ------------------------------------------------------------
    sequence s_nmi_rise_sel;
        st_reg.ctl[8] && $rose(nmi_filt);
    endsequence

    sequence s_nmi_presented;
        cpu_req_out && cpu_req_src_out == eisc_pkg::SRC_NMI &&
        cpu_req_level_out == eisc_pkg::LVL_NMI;
    endsequence

    chk_nmi_rise: assert property (
        s_nmi_rise_sel |-> ##2 s_nmi_presented)
        else $error("Rising non-maskable edge not forwarded");

    // An older pending request may stand, so only a fresh set is checked
    chk_nmi_wrong_edge: assert property (
        !st_reg.ctl[8] && $rose(nmi_filt) && !st_reg.pend[8] |=> !st_reg.pend[8])
        else $error("Rising edge raised a request with falling select");

    chk_nmi_wins: assert property (
        st_reg.pend[8] |=> s_nmi_presented)
        else $error("Pending non-maskable source lost arbitration");

    chk_ack_clears: assert property (
        cpu_ack_in && cpu_ack_src_in == eisc_pkg::SRC_NMI && !nmi_edge |=> !st_reg.pend[8])
        else $error("Acknowledge did not clear the pending source");

    chk_idle_no_req: assert property (
        active == 9'h000 |=> !cpu_req_out)
        else $error("Request presented with no active source");

    chk_notify_reset: assert property (
        @(posedge mclk_in) disable iff (1'b0)
        !reset_n_in |=> request_notify_n_out && !cpu_req_out)
        else $error("Outputs not idle after reset");

    // ------------------------------------------------------------
    // Detection and status checks
    // ------------------------------------------------------------
    chk_edge_pending: assert property (
        edge_evt != 8'h00 |=> (st_reg.pend[7:0] & $past(edge_evt)) == $past(edge_evt))
        else $error("Edge event not held pending");

    chk_level_no_edge: assert property (
        !st_reg.ctl[0] |=> !edge_evt[7])
        else $error("Edge event from an input in level mode");

    // Status bits drop only through a write of one
    chk_stat_sticky: assert property (
        !(reg_wr_in && reg_addr_in == eisc_pkg::OFS_STATUS) |=>
        (st_reg.stat & $past(st_reg.stat)) == $past(st_reg.stat))
        else $error("Status bit dropped without a clear");

    chk_set_wins: assert property (
        events != 9'h000 |=> (st_reg.stat & $past(events)) == $past(events))
        else $error("Same-cycle clear beat a status event");
endmodule

// [rtl/eisc_noise_filter.sv]
// Two-stage synchroniser and stability filter for the non-maskable pin
`timescale 1ns/1ps
module eisc_noise_filter (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic reset_n_in,
    // Pin and filtered level
    input  wire logic raw_in,
    output logic      filt_out
);
    localparam int HOLD_LAST = eisc_pkg::NF_CYCLES - 1;

    typedef struct packed {
        logic                          s1;
        logic                          s2;
        logic [eisc_pkg::NF_CNT_W-1:0] cnt;
        logic                          filt;
    } eisc_nf_s;

    eisc_nf_s st_reg;
    eisc_nf_s st_next;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = raw_in;
        st_next.s2 = st_reg.s1;
        // Glitches shorter than the hold time never reach filt
        if (st_reg.s2 != st_reg.filt) begin
            if (st_reg.cnt == eisc_pkg::NF_CNT_W'(HOLD_LAST)) begin
                st_next.filt = st_reg.s2;
                st_next.cnt  = '0;
            end else begin
                st_next.cnt = st_reg.cnt + 1'b1;
            end
        end else begin
            st_next.cnt = '0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign filt_out = st_reg.filt;

    chk_filter_hold: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        $changed(filt_out) |-> $past(st_reg.cnt) == eisc_pkg::NF_CNT_W'(HOLD_LAST))
        else $error("Filtered level changed before the hold time");
endmodule

// [rtl/eisc_pkg.sv]
// Shared constants for the external request sense and forwarding block
package eisc_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int N_EXT    = 8;
    localparam int N_SRC    = 9;
    localparam int PRIO_W   = 4;
    localparam int LVL_W    = 5;
    localparam int NF_CNT_W = 3;
    // ------------------------------------------------------------
    // Register offsets and layout
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_SENSE   = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_MASK    = 8'h08;
    localparam int          NONMASK_PIN_LEVEL_BIT    = 15;
    localparam int          RSVD_HI     = 14;
    localparam int          RSVD_LO     = 9;
    localparam int          NONMASK_EDGE_SELECT_BIT    = 8;
    localparam logic [8:0]  SENSE_RST   = 9'h000;
    localparam logic [8:0]  STATUS_RST  = 9'h000;
    localparam logic [8:0]  MASK_RST    = 9'h000;
    localparam logic [5:0]  RSVD_VAL    = 6'h00;
    // ------------------------------------------------------------
    // Sources and levels
    // ------------------------------------------------------------
    localparam logic [3:0]  SRC_NMI     = 4'h8;
    localparam logic [4:0]  LVL_NMI     = 5'h10;
    localparam logic [4:0]  LVL_NONE    = 5'h00;
    localparam logic [3:0]  PRIO_OFF    = 4'h0;
    // ------------------------------------------------------------
    // Edge direction codes
    // ------------------------------------------------------------
    localparam logic [1:0]  DIR_FALL    = 2'b00;
    localparam logic [1:0]  DIR_RISE    = 2'b01;
    localparam logic [1:0]  DIR_BOTH    = 2'b10;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int NF_TIME_NS    = 32;
    localparam int NF_CYCLES     = (NF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// [tb/eisc_cpu_model.sv]
// Behavioural CPU core that takes presented requests and acknowledges them
`timescale 1ns/1ps
module eisc_cpu_model (
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    // Presented request
    input  wire logic       req_in,
    input  wire logic [3:0] src_in,
    // Behaviour control from the bench
    input  wire logic       en_in,
    input  wire logic [3:0] dly_in,
    // Acknowledge
    output logic            ack_out,
    output logic      [3:0] ack_src_out
);
    logic [4:0] cnt_reg;

    // Three idle cycles at least, so a dropping request is never acked twice
    always_ff @(posedge mclk_in) begin
        ack_out <= 1'b0;
        ack_src_out <= ~ack_src_out;
        if (!reset_n_in || !req_in || !en_in || ack_out) begin
            cnt_reg <= 5'h00;
        end else if (cnt_reg >= 5'({1'b0, dly_in}) + 5'h03) begin
            ack_out <= 1'b1;
            ack_src_out <= src_in;
        end else begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the request sense and forwarding block
`timescale 1ns/1ps
module testbench;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        nmi = 1'b0;
    logic [7:0]  ext_n = 8'hff;
    logic [15:0] dir = 16'h0000;
    logic [31:0] prio = 32'h5090_9032;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        ack;
    logic [3:0]  ack_src;
    logic        req;
    logic [3:0]  src;
    logic [4:0]  lvl;
    logic        notify_n;
    logic        irq;
    logic        en = 1'b1;
    logic [3:0]  dly = 4'h0;
    int          n_fail = 0;
    int          checked = 0;

    initial begin
        forever #4 mclk = ~mclk;
    end

    eisc_ext_irq_sense_config u_eisc_ext_irq_sense_config (
        .mclk_in(mclk), .reset_n_in(rst_n), .nonmask_req_in(nmi),
        .ext_request_n_in(ext_n), .edge_direction_control_in(dir),
        .src_priority_in(prio), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .cpu_ack_in(ack), .cpu_ack_src_in(ack_src), .cpu_req_out(req),
        .cpu_req_src_out(src), .cpu_req_level_out(lvl),
        .request_notify_n_out(notify_n), .irq_out(irq));

    eisc_cpu_model u_eisc_cpu_model (
        .mclk_in(mclk), .reset_n_in(rst_n), .req_in(req), .src_in(src),
        .en_in(en), .dly_in(dly), .ack_out(ack), .ack_src_out(ack_src));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 check(rdata, e);
    endtask

    // Bounded wait for a request, then compare source, level and pin
    task automatic wait_req(input logic [3:0] s, input logic [4:0] l);
        int i;
        for (i = 0; i < 40 && req !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        if (i == 40) begin
            n_fail++;
            tally_and_finish();
        end
        check(16'({req, src, lvl, notify_n}), 16'({1'b1, s, l, 1'b0}));
    endtask

    task automatic wait_idle;
        int i;
        for (i = 0; i < 40 && req !== 1'b0; i++) begin
            @(posedge mclk);
            #1;
        end
        if (i == 40) begin
            n_fail++;
            tally_and_finish();
        end
    endtask

    task automatic no_req(input int n);
        repeat (n) @(posedge mclk);
        #1 check(16'({req, notify_n}), 16'h0001);
    endtask

    task automatic edge_try(input logic v, input logic exp);
        @(posedge mclk);
        ext_n[0] <= v;
        if (exp) begin
            wait_req(4'h0, 5'h02);
            wait_idle();
        end else begin
            no_req(12);
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        reg_rd(8'h00, 16'h0000);
        reg_rd(8'h04, 16'h0000);
        reg_rd(8'h0c, 16'h0000);
        reg_wr(8'h00, 16'h81ff);
        reg_rd(8'h00, 16'h01ff);
        reg_wr(8'h00, 16'h0000);
        // Level mode, arbitration with a tie and a disabled source
        @(posedge mclk);
        ext_n <= 8'h94;
        @(posedge mclk);
        #1 check(16'(req), 16'h0000);
        wait_req(4'h3, 5'h09);
        repeat (20) @(posedge mclk);
        wait_req(4'h3, 5'h09);
        ext_n <= 8'hbc;
        repeat (6) @(posedge mclk);
        wait_req(4'h1, 5'h03);
        ext_n <= 8'hbf;
        no_req(10);
        ext_n <= 8'hff;
        // Every edge direction code on input 0, slow and prompt acks
        reg_wr(8'h00, 16'h0080);
        for (int c = 0; c < 4; c++) begin
            dir <= {2'(c), 14'h0000};
            dly <= 4'(3 * c);
            edge_try(1'b0, c == 0 || c == 2);
            edge_try(1'b1, c == 1 || c == 2);
        end
        // Input 7 at bit 0: edge request ends with ack though pin stays low
        dir <= 16'h0000;
        reg_wr(8'h00, 16'h0001);
        ext_n[7] <= 1'b0;
        wait_req(4'h7, 5'h05);
        wait_idle();
        no_req(8);
        ext_n <= 8'hff;
        // Sticky status, mask and event interrupt
        reg_rd(8'h04, 16'h00eb);
        #1 check(16'(irq), 16'h0000);
        reg_wr(8'h08, 16'h0002);
        @(posedge mclk);
        #1 check(16'(irq), 16'h0001);
        reg_rd(8'h08, 16'h0002);
        reg_wr(8'h04, 16'h0002);
        @(posedge mclk);
        #1 check(16'(irq), 16'h0000);
        reg_rd(8'h04, 16'h00e9);
        reg_wr(8'h04, 16'h01ff);
        reg_wr(8'h08, 16'h0100);
        reg_wr(8'h00, 16'h0000);
        // Non-maskable: glitch, wrong edge, falling then rising select
        @(posedge mclk);
        nmi <= 1'b1;
        repeat (2) @(posedge mclk);
        nmi <= 1'b0;
        no_req(10);
        reg_rd(8'h00, 16'h0000);
        nmi <= 1'b1;
        no_req(12);
        reg_rd(8'h00, 16'h8000);
        nmi <= 1'b0;
        wait_req(4'h8, 5'h10);
        wait_idle();
        reg_wr(8'h00, 16'h0100);
        nmi <= 1'b1;
        wait_req(4'h8, 5'h10);
        wait_idle();
        reg_rd(8'h00, 16'h8100);
        #1 check(16'(irq), 16'h0001);
        reg_wr(8'h04, 16'h0100);
        @(posedge mclk);
        #1 check(16'(irq), 16'h0000);
        tally_and_finish();
    end
endmodule
